// ### common/sli_pkg.sv
// Purpose: Shared constants and types of the shared-line interrupt block.
// Assumes: Registers are byte wide and addressed by a 5-bit register index.
// Notes: Offsets are register indices as used by the serial engine.
package sli_pkg;

    // ========================================================================
    // Register map.
    // ========================================================================
    localparam logic [4:0] OFF_DEVICE_SETUP = 5'h0e;
    localparam logic [4:0] OFF_IRQ_POLARITY_RC_TRIM = 5'h11;
    localparam logic [4:0] OFF_CONDITION_FLAGS = 5'h1a;
    localparam logic [4:0] PAGED_LO = 5'h10;
    localparam logic [4:0] PAGED_HI = 5'h17;
    localparam logic PAGE_OF_TRIM = 1'b0;

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int SETUP_IRQ_CLEAR_BIT = 1;
    localparam int TRIM_POLARITY_BIT = 6;
    localparam int TRIM_RC_MSB = 5;
    localparam int FLAG_FLL_LOCKED_BIT = 0;
    localparam int FLAG_IRQ_PENDING_BIT = 1;
    localparam int FLAG_PARITY_ERR_BIT = 2;
    localparam int FLAG_BATTERY_LOW_BIT = 3;
    localparam int FLAG_AUTO_SHUTDOWN_BIT = 4;
    localparam int FLAG_XTAL_STABLE_BIT = 7;
    localparam logic [7:0] DEVICE_SETUP_RST = 8'h88;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [7:0] CONDITION_FLAGS_RST = 8'h00;

    // ========================================================================
    // Timing.
    // ========================================================================
    localparam int PULSE_TICKS = 4;
    localparam int SYNC_STAGES = 3;

    // Configuration register, bit 7 down to bit 0.
    typedef struct packed {
        logic crystal_rewrite_en;
        logic page_sel;
        logic force_hf_osc_running;
        logic output_clock_src;
        logic output_clock_gate;
        logic watchdog_clock_choice;
        logic irq_clear;
        logic irq_enable;
    } sli_setup_s;

    // Register access from the serial frame engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } sli_reg_req_s;

endpackage : sli_pkg

// ### core/sli_pin_sync.sv
// Purpose: Brings the shared pin level into the clock domain.
// Assumes: The pin is asynchronous to sys_clk_i.
// Notes: The output follows only when the last two stages agree.
module sli_pin_sync #(
    parameter int STAGES = sli_pkg::SYNC_STAGES
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Pin and result.
    input wire logic pin_i,
    output logic level_o
);

    logic [STAGES-1:0] stage;

    // Refuse any chain other than the three stages the agreement check uses.
    if (STAGES != 3) begin : g_bad_stages
        $error("sli_pin_sync needs exactly three stages");
    end

    // Shift the pin through the chain.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            stage <= '0;
        end else begin
            stage <= {stage[STAGES-2:0], pin_i};
        end
    end

    // Accept a new level once the second and third stages agree.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            level_o <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level_o <= stage[2];
        end
    end

endmodule : sli_pin_sync

// ### core/sli_irq_line.sv
// Purpose: Interrupt signalling on the shared serial pin plus its neighbour registers.
// Assumes: Serial framing lives outside; it hands register accesses and pin drive here.
// Notes: Output clock cycles arrive as one-cycle enable pulses on output_clock_tick_i.

// Notes on behaviour
// R1: The serial pin doubles as the interrupt request output to the host.
// R2: Polarity bit 6 of trim register: 1 drives active high, 0 active low.
// R3: An interrupt holds the pin active four output clock cycles, then inactive.
// R4: Periodic timer end of count raises an interrupt.
// R5: Interrupts signal only while configuration bit 0 is set.
// R6: Writing 1 to configuration bit 1 clears pending; reads as 0.
// R7: Status bit 1 shows 1 while an interrupt is pending.
// R8: Status bit 2 sets on a serial parity error.
// R9: Configuration bit 6 selects page for addresses 0x10 to 0x17.
// R10: Configuration bit 4 picks output clock source; register resets to 0x88.
// R11: Configuration bit 3 gates the output clock pin.
// R12: Configuration bit 2 picks the watchdog clock.
// R13: Configuration bit 5 keeps the high frequency oscillator always running.
// R14: Configuration bit 7 resets only on power-on; others also on watchdog, brownout.
// R15: Trim bits 0 to 5 tune the RC oscillator, about 330 Hz a step.
// R16: Status clears on all resets; bit 4 shows auto clock shut-down.
// R17: Status bit 0 shows frequency locked loop lock.
// R18: Status bit 7 shows the crystal oscillator is stable.
// R19: Polarity writes are blocked once the application write-protect flag is set.
// R20: Pending stays set until cleared; pulses wait for serial transfers to end.
// R21: The trim register is reached only with page 0 selected.
module sli_irq_line #(
    parameter int PULSE_LEN = sli_pkg::PULSE_TICKS
) (
    // Clock and power-on reset.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Other reset sources, one-cycle pulses.
    input wire logic wdog_rst_i,
    input wire logic brownout_rst_i,
    // Shared pin, three-signal form.
    input wire logic io_pin_i,
    output logic io_pin_o,
    output logic io_pin_oe_o,
    output logic io_rx_o,
    // Serial engine side.
    input wire sli_pkg::sli_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic serial_busy_i,
    input wire logic serial_drive_i,
    input wire logic serial_out_i,
    input wire logic parity_err_i,
    // Events and state from neighbouring blocks.
    input wire logic output_clock_tick_i,
    input wire logic timer_eoc_i,
    input wire logic app_write_protect_i,
    input wire logic fll_locked_i,
    input wire logic battery_low_i,
    input wire logic auto_shutdown_i,
    input wire logic xtal_stable_i,
    // Configuration outputs.
    output logic page_sel_o,
    output logic force_hf_osc_running_o,
    output logic output_clock_src_o,
    output logic output_clock_gate_o,
    output logic watchdog_clock_choice_o,
    output logic crystal_rewrite_en_o,
    output logic [5:0] rc_trim_o,
    output logic irq_pending_o
);

    // ========================================================================
    // Declarations.
    // ========================================================================
    typedef enum logic [1:0] {
        SLI_IDLE,
        SLI_WAIT,
        SLI_PULSE
    } sli_pulse_e;

    sli_pkg::sli_setup_s device_setup;
    logic [7:0] irq_polarity_rc_trim;
    logic [7:0] condition_flags;
    logic irq_pending;
    logic parity_seen;
    sli_pulse_e pulse_state;
    logic [2:0] tick_count;
    logic soft_rst;
    logic wr_setup;
    logic wr_trim;
    logic irq_event;
    logic irq_clear;
    logic next_pin;
    logic next_oe;

    // Refuse a pulse length the counter cannot hold.
    if (PULSE_LEN < 1 || PULSE_LEN > 7) begin : g_bad_pulse_len
        $error("sli_irq_line PULSE_LEN must be 1 to 7");
    end

    // Tells whether an address hits a register, honouring the page bit.
    function automatic logic reg_hit(input logic [4:0] addr, input logic page,
                                     input logic [4:0] off);
        logic paged;
        paged = (off >= sli_pkg::PAGED_LO) && (off <= sli_pkg::PAGED_HI);
        reg_hit = (addr == off) && (!paged || (page == sli_pkg::PAGE_OF_TRIM));
    endfunction : reg_hit

    // ========================================================================
    // Decode.
    // ========================================================================
    // Watchdog and brownout reset setup, trim, pending, parity, status and pulse state, not the rewrite enable or read data.
    assign soft_rst = wdog_rst_i || brownout_rst_i;
    assign wr_setup = reg_req_i.wr &&
        reg_hit(reg_req_i.addr, device_setup.page_sel, sli_pkg::OFF_DEVICE_SETUP);
    assign wr_trim = reg_req_i.wr && reg_hit(reg_req_i.addr, device_setup.page_sel,
        sli_pkg::OFF_IRQ_POLARITY_RC_TRIM); // R21
    assign irq_event = timer_eoc_i && device_setup.irq_enable; // R4 R5
    assign irq_clear = wr_setup && reg_req_i.wdata[sli_pkg::SETUP_IRQ_CLEAR_BIT]; // R6

    // ========================================================================
    // Registers.
    // ========================================================================
    // Configuration; bit 7 follows power-on only and the clear bit is never stored.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            device_setup <= sli_pkg::DEVICE_SETUP_RST; // R10
        end else begin
            if (wr_setup) begin
                device_setup.crystal_rewrite_en <= reg_req_i.wdata[7]; // R14
            end
            if (soft_rst) begin
                device_setup[6:0] <= sli_pkg::DEVICE_SETUP_RST[6:0]; // R10 R14
            end else if (wr_setup) begin
                device_setup[6:2] <= reg_req_i.wdata[6:2]; // R9 R10 R11 R12 R13
                device_setup.irq_clear <= 1'b0; // R6
                device_setup.irq_enable <= reg_req_i.wdata[0]; // R5
            end
        end
    end

    // Trim register; polarity is guarded by the application write protect.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || soft_rst) begin
            irq_polarity_rc_trim <= sli_pkg::TRIM_RST;
        end else if (wr_trim) begin
            irq_polarity_rc_trim[sli_pkg::TRIM_RC_MSB:0] <=
                reg_req_i.wdata[sli_pkg::TRIM_RC_MSB:0]; // R15
            if (!app_write_protect_i) begin
                irq_polarity_rc_trim[sli_pkg::TRIM_POLARITY_BIT] <=
                    reg_req_i.wdata[sli_pkg::TRIM_POLARITY_BIT]; // R19
            end
        end
    end

    // Pending flag; a new event beats a clear in the same cycle.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || soft_rst) begin
            irq_pending <= 1'b0;
        end else if (irq_event) begin
            irq_pending <= 1'b1; // R20
        end else if (irq_clear) begin
            irq_pending <= 1'b0; // R6
        end
    end

    // Sticky parity error, cleared only by a reset.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || soft_rst) begin
            parity_seen <= 1'b0;
        end else if (parity_err_i) begin
            parity_seen <= 1'b1; // R8
        end
    end

    // Status image, captured each cycle so it clears on every reset.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || soft_rst) begin
            condition_flags <= sli_pkg::CONDITION_FLAGS_RST; // R16
        end else begin
            condition_flags <= sli_pkg::CONDITION_FLAGS_RST;
            condition_flags[sli_pkg::FLAG_FLL_LOCKED_BIT] <= fll_locked_i; // R17
            condition_flags[sli_pkg::FLAG_IRQ_PENDING_BIT] <= irq_event || irq_pending; // R7
            condition_flags[sli_pkg::FLAG_PARITY_ERR_BIT] <= parity_err_i || parity_seen; // R8
            condition_flags[sli_pkg::FLAG_BATTERY_LOW_BIT] <= battery_low_i;
            condition_flags[sli_pkg::FLAG_AUTO_SHUTDOWN_BIT] <= auto_shutdown_i; // R16
            condition_flags[sli_pkg::FLAG_XTAL_STABLE_BIT] <= xtal_stable_i; // R18
        end
    end

    // Read data, registered one cycle after the read strobe.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            if (reg_hit(reg_req_i.addr, device_setup.page_sel, sli_pkg::OFF_DEVICE_SETUP)) begin
                reg_rdata_o <= device_setup; // R6
            end else if (reg_hit(reg_req_i.addr, device_setup.page_sel,
                                 sli_pkg::OFF_IRQ_POLARITY_RC_TRIM)) begin
                reg_rdata_o <= irq_polarity_rc_trim & 8'h7f;
            end else if (reg_hit(reg_req_i.addr, device_setup.page_sel,
                                 sli_pkg::OFF_CONDITION_FLAGS)) begin
                reg_rdata_o <= condition_flags; // R7
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // ========================================================================
    // Interrupt pulse on the shared pin.
    // ========================================================================
    // Requests wait out serial traffic, then last PULSE_LEN output clock ticks.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || soft_rst) begin
            pulse_state <= SLI_IDLE;
            tick_count <= 3'h0;
        end else begin
            case (pulse_state)
                SLI_IDLE: begin
                    if (irq_event) begin
                        pulse_state <= SLI_WAIT; // R4
                    end
                end
                SLI_WAIT: begin
                    tick_count <= 3'h0;
                    if (!serial_busy_i) begin
                        pulse_state <= SLI_PULSE; // R20
                    end
                end
                SLI_PULSE: begin
                    if (output_clock_tick_i) begin
                        if (tick_count == 3'(PULSE_LEN - 1)) begin
                            pulse_state <= SLI_IDLE; // R3
                        end else begin
                            tick_count <= tick_count + 3'h1;
                        end
                    end
                end
                default: begin
                    pulse_state <= SLI_IDLE;
                end
            endcase
        end
    end

    // Serial drive has the pin first; otherwise the pulse level or inactive.
    always_comb begin
        next_oe = serial_drive_i || (pulse_state == SLI_PULSE); // R1
        if (serial_drive_i) begin
            next_pin = serial_out_i;
        end else if (pulse_state == SLI_PULSE) begin
            next_pin = irq_polarity_rc_trim[sli_pkg::TRIM_POLARITY_BIT]; // R2
        end else begin
            next_pin = !irq_polarity_rc_trim[sli_pkg::TRIM_POLARITY_BIT]; // R3
        end
    end

    // Pin outputs come straight from flip-flops.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            io_pin_o <= 1'b1;
            io_pin_oe_o <= 1'b0;
        end else begin
            io_pin_o <= next_pin;
            io_pin_oe_o <= next_oe;
        end
    end

    // Configuration mirrors as flops.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            {page_sel_o, force_hf_osc_running_o, output_clock_src_o} <= 3'h0;
            {output_clock_gate_o, watchdog_clock_choice_o} <= 2'h0;
            crystal_rewrite_en_o <= 1'b0;
            rc_trim_o <= 6'h00;
            irq_pending_o <= 1'b0;
        end else begin
            page_sel_o <= device_setup.page_sel; // R9
            force_hf_osc_running_o <= device_setup.force_hf_osc_running; // R13
            output_clock_src_o <= device_setup.output_clock_src; // R10
            output_clock_gate_o <= device_setup.output_clock_gate; // R11
            watchdog_clock_choice_o <= device_setup.watchdog_clock_choice; // R12
            crystal_rewrite_en_o <= device_setup.crystal_rewrite_en;
            rc_trim_o <= irq_polarity_rc_trim[sli_pkg::TRIM_RC_MSB:0]; // R15
            irq_pending_o <= irq_pending;
        end
    end

    // Receive path for the serial engine.
    sli_pin_sync #(
        .STAGES(sli_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(io_pin_i),
        .level_o(io_rx_o)
    );

    // ========================================================================
    // Assertions.
    // ========================================================================
    property p_pulse_level;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pulse_state == SLI_PULSE) && !serial_drive_i |=>
            io_pin_oe_o && (io_pin_o == $past(irq_polarity_rc_trim[6]));
    endproperty
    a_pulse_level: assert property (p_pulse_level) else $error("pulse level wrong"); // R2

    property p_pulse_end;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pulse_state == SLI_PULSE) && output_clock_tick_i && !soft_rst &&
            (tick_count == 3'(PULSE_LEN - 1)) |=> (pulse_state == SLI_IDLE);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end"); // R3

    property p_event_pending;
        @(posedge sys_clk_i) disable iff (!rstn_i || soft_rst)
        timer_eoc_i && device_setup.irq_enable |=> irq_pending ##1 irq_pending_o;
    endproperty
    a_event_pending: assert property (p_event_pending) else $error("event lost"); // R4

    property p_disabled;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !device_setup.irq_enable && !irq_pending && (pulse_state == SLI_IDLE) |=>
            !irq_pending && (pulse_state == SLI_IDLE);
    endproperty
    a_disabled: assert property (p_disabled) else $error("irq while disabled"); // R5

    property p_clear;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        irq_clear && !irq_event |=> !irq_pending && !device_setup.irq_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed"); // R6

    property p_status_read;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        reg_req_i.rd && (reg_req_i.addr == sli_pkg::OFF_CONDITION_FLAGS) |=>
            reg_rdata_o[1] == $past(condition_flags[1]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong"); // R7

    property p_parity;
        @(posedge sys_clk_i) disable iff (!rstn_i || soft_rst)
        parity_err_i |=> parity_seen ##1 condition_flags[2];
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag missing"); // R8

    property p_protect;
        @(posedge sys_clk_i) disable iff (!rstn_i || soft_rst)
        wr_trim && app_write_protect_i |=> $stable(irq_polarity_rc_trim[6]);
    endproperty
    a_protect: assert property (p_protect) else $error("protected write landed"); // R19

    property p_wait_busy;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (pulse_state == SLI_WAIT) && serial_busy_i |=> (pulse_state != SLI_PULSE);
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("pulse during transfer"); // R20

    property p_rewrite_keep;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        soft_rst && !wr_setup |=> $stable(device_setup.crystal_rewrite_en);
    endproperty
    a_rewrite_keep: assert property (p_rewrite_keep) else $error("bit 7 reset"); // R14

endmodule : sli_irq_line

// ### verification/sli_host_model.sv
// Purpose: Host side of the shared serial and interrupt pin.
// Assumes: The block drives the pin through a value and an enable.
// Notes: An undriven line toggles every cycle so no stale level is seen.
module sli_host_model (
    // Clock.
    input wire logic sys_clk_i,
    // Pin drive from the block and resolved level.
    input wire logic pin_drv_i,
    input wire logic pin_oe_i,
    output logic line_o
);
    logic float_q = 1'b0;

    // Pattern shown while nobody drives the line.
    always @(posedge sys_clk_i) float_q <= ~float_q;

    // Wire level seen by the host and fed back to the block.
    assign line_o = pin_oe_i ? pin_drv_i : float_q;
endmodule : sli_host_model

// ### verification/sli_irq_line_tb.sv
// Purpose: Self-checking bench of the shared-line interrupt block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Output clock ticks are made only while a pulse is seen.
module sli_irq_line_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] A_SET = sli_pkg::OFF_DEVICE_SETUP;
    localparam logic [4:0] A_TRM = sli_pkg::OFF_IRQ_POLARITY_RC_TRIM;
    localparam logic [4:0] A_FLG = sli_pkg::OFF_CONDITION_FLAGS;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic wdog = 1'b0, bo = 1'b0, busy = 1'b0, sdrv = 1'b0, sout = 1'b0, perr = 1'b0;
    logic tick = 1'b0, eoc = 1'b0, wp = 1'b0, fll = 1'b0, bat = 1'b0, ash = 1'b0, xs = 1'b0;
    sli_pkg::sli_reg_req_s req = '0;
    logic line, pin_o, pin_oe, pg, frc, src, gate, wcl, rew, pend, rx;
    logic [7:0] rdata;
    logic [5:0] trim;
    int err_total = 0;
    int checks_done = 0;

    // ========================================================================
    // Clock, block and host.
    // ========================================================================
    // Clock of 50 ns period.
    always #25 sys_clk = ~sys_clk;

    sli_irq_line u_sli_irq_line (.sys_clk_i(sys_clk), .rstn_i(rstn), .wdog_rst_i(wdog),
        .brownout_rst_i(bo), .io_pin_i(line), .io_pin_o(pin_o), .io_pin_oe_o(pin_oe),
        .io_rx_o(rx), .reg_req_i(req), .reg_rdata_o(rdata), .serial_busy_i(busy),
        .serial_drive_i(sdrv), .serial_out_i(sout), .parity_err_i(perr),
        .output_clock_tick_i(tick), .timer_eoc_i(eoc), .app_write_protect_i(wp),
        .fll_locked_i(fll), .battery_low_i(bat), .auto_shutdown_i(ash), .xtal_stable_i(xs),
        .page_sel_o(pg), .force_hf_osc_running_o(frc), .output_clock_src_o(src),
        .output_clock_gate_o(gate), .watchdog_clock_choice_o(wcl),
        .crystal_rewrite_en_o(rew), .rc_trim_o(trim), .irq_pending_o(pend));

    sli_host_model u_sli_host_model (.sys_clk_i(sys_clk), .pin_drv_i(pin_o),
        .pin_oe_i(pin_oe), .line_o(line));

    // ========================================================================
    // Shared tasks.
    // ========================================================================
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // One register write, entered and left at a falling edge.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge sys_clk);
        req = '0;
        @(negedge sys_clk); // Idle cycle; lets the mirrors follow the write.
    endtask : wr

    // One register read compared with the expected byte.
    task automatic rchk(input string w, input logic [4:0] a, input logic [7:0] e);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge sys_clk);
        req = '0;
        chk(w, e, rdata);
        @(negedge sys_clk);
    endtask : rchk

    // One-cycle pulse on the timer end of count.
    task automatic fire;
        eoc = 1'b1;
        @(negedge sys_clk);
        eoc = 1'b0;
    endtask : fire

    // Ticks while the pulse lasts; returns how many were given.
    task automatic run_ticks(output int n);
        n = 0;
        for (int i = 0; i < 80 && pin_oe === 1'b1; i++) begin
            tick = (i % 5 == 4);
            n += tick;
            @(negedge sys_clk);
        end
        tick = 1'b0;
    endtask : run_ticks

    // ========================================================================
    // Scenarios.
    // ========================================================================
    // Reset values, configuration mirrors, trim, protection and paging.
    task automatic t_regs;
        rchk("setup reset", A_SET, 8'h88);
        rchk("flags reset", A_FLG, 8'h00);
        rchk("unmapped", 5'h05, 8'h00);
        chk("gate and rewrite", {6'h0, gate, rew}, 8'h03);
        wr(A_SET, 8'hbc);
        chk("mirrors on", {4'h0, frc, src, gate, wcl}, 8'h0f);
        wr(A_SET, 8'h80);
        chk("mirrors off", {4'h0, frc, src, gate, wcl}, 8'h00);
        wr(A_TRM, 8'hff);
        rchk("trim", A_TRM, 8'h7f);
        chk("trim out", {2'h0, trim}, 8'h3f);
        wp = 1'b1;
        wr(A_TRM, 8'h05);
        rchk("protected polarity", A_TRM, 8'h45);
        wp = 1'b0;
        wr(A_SET, 8'hc0);
        chk("page out", {7'h0, pg}, 8'h01);
        rchk("trim on page 1", A_TRM, 8'h00);
        wr(A_SET, 8'h80);
        rchk("trim on page 0", A_TRM, 8'h45);
        wr(A_FLG, 8'hff);
        rchk("flags read only", A_FLG, 8'h00);
    endtask : t_regs

    // Pulse of both polarities, pending flag and its clear.
    task automatic t_irq;
        int n;
        for (int p = 0; p < 2; p++) begin
            wr(A_TRM, {1'b0, p[0], 6'h00});
            wr(A_SET, 8'h01);
            fire();
            for (int i = 0; i < 10 && pin_oe !== 1'b1; i++) @(negedge sys_clk);
            chk("active level", {7'h0, pin_o}, {7'h0, p[0]});
            run_ticks(n);
            chk("ticks in pulse", n[7:0], 8'h04);
            chk("inactive level", {7'h0, pin_o}, {7'h0, ~p[0]});
            rchk("pending", A_FLG, 8'h02);
            chk("pending out", {7'h0, pend}, 8'h01);
            wr(A_SET, 8'h03);
            @(negedge sys_clk);
            rchk("cleared", A_FLG, 8'h00);
            rchk("clear reads 0", A_SET, 8'h01);
        end
    endtask : t_irq

    // Events while disabled are dropped.
    task automatic t_off;
        logic seen;
        seen = 1'b0;
        wr(A_SET, 8'h00);
        fire();
        repeat (20) begin
            seen |= pin_oe;
            @(negedge sys_clk);
        end
        chk("disabled drive", {7'h0, seen}, 8'h00);
        rchk("disabled pending", A_FLG, 8'h00);
    endtask : t_off

    // A pulse waits while a serial transfer owns the pin.
    task automatic t_busy;
        int n;
        wr(A_SET, 8'h01);
        busy = 1'b1;
        sdrv = 1'b1;
        fire();
        repeat (12) @(negedge sys_clk);
        chk("serial owns pin", {5'h0, rx, pin_oe, pin_o}, 8'h02);
        chk("pending in busy", {7'h0, pend}, 8'h01);
        busy = 1'b0;
        sdrv = 1'b0;
        for (int i = 0; i < 10 && !(pin_oe === 1'b1 && pin_o === 1'b1); i++)
            @(negedge sys_clk);
        chk("late pulse", {6'h0, pin_oe, pin_o}, 8'h03);
        run_ticks(n);
        chk("late ticks", n[7:0], 8'h04);
        chk("rx after pulse", {7'h0, rx}, 8'h01);
        wr(A_SET, 8'h02);
    endtask : t_busy

    // Status inputs, sticky parity and the other reset sources.
    task automatic t_flags;
        {fll, bat, ash, xs, perr} = 5'h1f;
        @(negedge sys_clk);
        perr = 1'b0;
        repeat (2) @(negedge sys_clk);
        rchk("status set", A_FLG, 8'h9d);
        {fll, bat, ash, xs} = 4'h0;
        repeat (2) @(negedge sys_clk);
        rchk("parity sticky", A_FLG, 8'h04);
        wr(A_SET, 8'h00);
        wdog = 1'b1;
        @(negedge sys_clk);
        wdog = 1'b0;
        @(negedge sys_clk);
        rchk("flags after watchdog", A_FLG, 8'h00);
        rchk("setup after watchdog", A_SET, 8'h08);
        wr(A_SET, 8'h05);
        bo = 1'b1;
        @(negedge sys_clk);
        bo = 1'b0;
        @(negedge sys_clk);
        rchk("setup after brownout", A_SET, 8'h08);
    endtask : t_flags

    // ========================================================================
    // Verdict, watchdog and main sequence.
    // ========================================================================
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #1ms;
        err_total++;
        final_report();
    end

    // Reset for 16 cycles, then the scenarios.
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        t_regs();
        t_irq();
        t_off();
        t_busy();
        t_flags();
        final_report();
    end
endmodule : sli_irq_line_tb
